/* File: logic/ogs_pkg.sv */
// ----------------------------------------------------------------
// Shared constants and types of the output gearbox
// ----------------------------------------------------------------
package ogs_pkg;

    // Word and lane widths
    localparam int OGS_WORD_W = 8; // Parallel word from the core
    localparam int OGS_LANES = 2; // Serial lanes towards the I/O buffer
    localparam int OGS_HALF_W = 4; // Bits per lane in four to one mode
    localparam int OGS_CNT_W = 3; // Width of the word slot counter

    // External encoding of the mode select input
    localparam logic [1:0] OGS_SEL_SEVEN = 2'h0; // Video 7:1
    localparam logic [1:0] OGS_SEL_EIGHT = 2'h1; // One 8:1 gearbox
    localparam logic [1:0] OGS_SEL_FOUR = 2'h2; // Two 4:1 gearboxes

    // Last slot count of each word period (ratio minus one)
    localparam logic [OGS_CNT_W-1:0] OGS_LAST_SEVEN = 3'h6;
    localparam logic [OGS_CNT_W-1:0] OGS_LAST_EIGHT = 3'h7;
    localparam logic [OGS_CNT_W-1:0] OGS_LAST_FOUR = 3'h3;

    // Reset values
    localparam logic [OGS_CNT_W-1:0] OGS_CNT_RST = 3'h0;
    localparam logic [OGS_WORD_W-1:0] OGS_WORD_RST = 8'h00;
    localparam logic [OGS_LANES-1:0] OGS_SER_RST = 2'h0;

    // Mask that keeps bits 6 down to 0 in video mode
    localparam logic [OGS_WORD_W-1:0] OGS_SEVEN_MASK = 8'h7f;

    // Gearbox modes
    typedef enum logic [1:0] {
        OGS_SEVEN,
        OGS_EIGHT,
        OGS_FOUR
    } ogs_mode_t;

    // Decode of the mode select input, spare code means eight to one
    function automatic ogs_mode_t ogs_decode(input logic [1:0] sel);
        ogs_mode_t m;
        case (sel)
            OGS_SEL_SEVEN: m = OGS_SEVEN;
            OGS_SEL_FOUR: m = OGS_FOUR;
            default: m = OGS_EIGHT;
        endcase
        return m;
    endfunction : ogs_decode

    // Last slot of a word period for a mode
    function automatic logic [OGS_CNT_W-1:0] ogs_last(input ogs_mode_t m);
        logic [OGS_CNT_W-1:0] l;
        case (m)
            OGS_SEVEN: l = OGS_LAST_SEVEN;
            OGS_FOUR: l = OGS_LAST_FOUR;
            default: l = OGS_LAST_EIGHT;
        endcase
        return l;
    endfunction : ogs_last

endpackage : ogs_pkg

/* File: logic/ogs_stage_if.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Hand-over from the second stage to the shifting stage
// ----------------------------------------------------------------
interface ogs_stage_if;
    import ogs_pkg::*;
    logic load; // One-cycle load of a new word
    logic [OGS_WORD_W-1:0] word; // Word held by the second stage
    logic four; // Word belongs to two 4:1 gearboxes
    logic [OGS_LANES-1:0] serial; // Serial lane bits, registered

    modport feed (output load, output word, output four, input serial);
    modport shift (input load, input word, input four, output serial);
endinterface : ogs_stage_if

/* File: logic/ogs_shifter.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Third stage: shift and mux the word onto the serial lanes
// ----------------------------------------------------------------
module ogs_shifter
    import ogs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    ogs_stage_if.shift st
);

    logic [OGS_WORD_W-1:0] sh_q; // Bits still to go out
    logic [OGS_WORD_W-1:0] sh_d;
    logic [OGS_LANES-1:0] out_q; // Bits on the lanes now
    logic [OGS_LANES-1:0] out_d;
    logic four_q; // Split mode of the word in flight
    logic four_d;
    logic [OGS_WORD_W-1:0] src; // Load word or remaining bits
    logic [OGS_WORD_W-1:0] split_next; // Next bits, two 4:1 lanes
    logic [OGS_LANES-1:0] split_out; // Lane bits, two 4:1 lanes

    // Each half shifts on its own in four to one mode
    genvar g;
    generate
        for (g = 0; g < OGS_LANES; g++) begin : g_half
            assign split_out[g] = src[g*OGS_HALF_W];
            assign split_next[g*OGS_HALF_W +: OGS_HALF_W] =
                {1'b0, src[g*OGS_HALF_W+1 +: OGS_HALF_W-1]};
        end
    endgenerate

    // Next lane bits, least significant bit first
    always_comb begin
        src = st.load ? st.word : sh_q;
        four_d = st.load ? st.four : four_q;
        if (four_d) begin
            // Lower lane from bits 3..0, upper lane from 7..4
            out_d = split_out;
            sh_d = split_next;
        end else begin
            // Single lane, upper lane rests low
            out_d = {1'b0, src[0]};
            sh_d = {1'b0, src[OGS_WORD_W-1:1]};
        end
    end

    // Shift registers
    always_ff @(posedge clk) begin
        if (reset) begin
            // Clear shift state
            sh_q <= OGS_WORD_RST;
            out_q <= OGS_SER_RST;
            four_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            out_q <= out_d;
            four_q <= four_d;
        end
    end

    assign st.serial = out_q;

endmodule : ogs_shifter

/* File: logic/ogs_serializer.sv */
`timescale 1ns/10ps
module ogs_serializer
    import ogs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] mode_sel,
    input wire logic [OGS_WORD_W-1:0] par_data,
    output logic word_take_q,
    output logic [OGS_LANES-1:0] serial_q
);

    // ------------------------------------------------------------
    // Word slot divider
    // ------------------------------------------------------------
    logic [OGS_CNT_W-1:0] cnt_q; // Slot within the word period
    logic [OGS_CNT_W-1:0] cnt_d;
    ogs_mode_t mode_q; // Mode of the current period
    ogs_mode_t mode_d;
    logic take_d; // Slow enable for next cycle

    // Period restarts after a take, mode switches only there
    always_comb begin
        cnt_d = word_take_q ? OGS_CNT_RST : cnt_q + 1'b1;
        mode_d = word_take_q ? ogs_decode(mode_sel) : mode_q;
        take_d = (cnt_d == ogs_last(mode_d));
    end

    // Divider registers
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= OGS_CNT_RST;
            mode_q <= OGS_EIGHT;
            word_take_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            mode_q <= mode_d;
            word_take_q <= take_d;
        end
    end

    // ------------------------------------------------------------
    // First and second pipeline stages
    // ------------------------------------------------------------
    logic [OGS_WORD_W-1:0] stage1_q; // Captured on the slow enable
    logic [OGS_WORD_W-1:0] stage1_d;
    logic four1_q; // Split mode with stage one
    logic four1_d;
    logic [OGS_WORD_W-1:0] stage2_q; // Held in the fast domain
    logic [OGS_WORD_W-1:0] stage2_d;
    logic four2_q;
    logic four2_d;
    logic xfer_q; // Stage one to stage two move
    logic load_q; // Stage two to shifter move
    ogs_mode_t cap_mode; // Mode applied to a captured word

    // Capture masks the unused bit in video mode
    always_comb begin
        cap_mode = ogs_decode(mode_sel);
        stage1_d = stage1_q;
        four1_d = four1_q;
        stage2_d = stage2_q;
        four2_d = four2_q;
        if (word_take_q) begin
            // Slow clock capture
            if (cap_mode == OGS_SEVEN) begin
                stage1_d = par_data & OGS_SEVEN_MASK;
            end else begin
                stage1_d = par_data;
            end
            four1_d = (cap_mode == OGS_FOUR);
        end
        if (xfer_q) begin
            // Slow to fast hand-over
            stage2_d = stage1_q;
            four2_d = four1_q;
        end
    end

    // Stage registers
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_q <= OGS_WORD_RST;
            stage2_q <= OGS_WORD_RST;
            four1_q <= 1'b0;
            four2_q <= 1'b0;
            xfer_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
            four1_q <= four1_d;
            four2_q <= four2_d;
            xfer_q <= word_take_q;
            load_q <= xfer_q;
        end
    end

    // ------------------------------------------------------------
    // Third pipeline stage
    // ------------------------------------------------------------
    ogs_stage_if st ();

    assign st.load = load_q;
    assign st.word = stage2_q;
    assign st.four = four2_q;

    // Shifter owns the output flops
    ogs_shifter u_shift (
        .clk(clk),
        .reset(reset),
        .st(st.shift)
    );

    assign serial_q = st.serial;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_latency; // Bit 0 out three cycles after take
        @(posedge clk) disable iff (reset)
        word_take_q |-> ##3 serial_q[0] == $past(par_data[0], 3);
    endproperty
    a_latency: assert property (p_latency)
        else $error("bit 0 not out three cycles after take");

    property p_capture; // Stage one holds the taken word
        @(posedge clk) disable iff (reset)
        word_take_q && mode_sel == OGS_SEL_EIGHT |=> stage1_q == $past(par_data);
    endproperty
    a_capture: assert property (p_capture)
        else $error("stage one missed the taken word");

    property p_handover; // Stage two follows stage one after take
        @(posedge clk) disable iff (reset)
        word_take_q ##1 xfer_q |=> stage2_q == $past(stage1_q) && load_q;
    endproperty
    a_handover: assert property (p_handover)
        else $error("stage two hand-over wrong");

    property p_eight_walk; // Second bit follows in 8:1
        @(posedge clk) disable iff (reset)
        load_q && !four2_q |=> ##1 serial_q[0] == $past(stage2_q[1], 2);
    endproperty
    a_eight_walk: assert property (p_eight_walk)
        else $error("serial bit order wrong");

    property p_seven_mask; // Bit 7 dropped in video mode
        @(posedge clk) disable iff (reset)
        word_take_q && mode_sel == OGS_SEL_SEVEN |=> !stage1_q[OGS_WORD_W-1];
    endproperty
    a_seven_mask: assert property (p_seven_mask)
        else $error("bit 7 kept in video mode");

    property p_upper_lane; // Upper lane starts with bit 4
        @(posedge clk) disable iff (reset)
        load_q && four2_q |=> serial_q[1] == $past(stage2_q[OGS_HALF_W]);
    endproperty
    a_upper_lane: assert property (p_upper_lane)
        else $error("upper lane start bit wrong");

    property p_lane_idle; // Upper lane low outside split mode
        @(posedge clk) disable iff (reset)
        load_q && !four2_q |=> !serial_q[1] [*3];
    endproperty
    a_lane_idle: assert property (p_lane_idle)
        else $error("upper lane active in single lane mode");

    property p_period; // Takes are at most eight cycles apart
        @(posedge clk) disable iff (reset)
        word_take_q |=> !word_take_q [*3] ##[1:5] word_take_q;
    endproperty
    a_period: assert property (p_period)
        else $error("word period out of range");

    property p_reset; // Reset clears pipeline and lanes
        @(posedge clk)
        reset |=> serial_q == OGS_SER_RST && !word_take_q && stage2_q == OGS_WORD_RST;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset left state behind");

    property p_stage1_hold; // Stage one moves only on the slow enable
        @(posedge clk) disable iff (reset)
        !word_take_q |=> $stable(stage1_q);
    endproperty
    a_stage1_hold: assert property (p_stage1_hold)
        else $error("stage one changed outside a take");

    property p_four_walk; // Second bit of both 4:1 lanes
        @(posedge clk) disable iff (reset)
        load_q && four2_q |=> ##1 serial_q == {$past(stage2_q[5], 2), $past(stage2_q[1], 2)};
    endproperty
    a_four_walk: assert property (p_four_walk)
        else $error("split lane bit order wrong");

    property p_four_period; // Two 4:1 gearboxes take every four cycles
        @(posedge clk) disable iff (reset)
        word_take_q && mode_sel == OGS_SEL_FOUR |=> !word_take_q [*3] ##1 word_take_q;
    endproperty
    a_four_period: assert property (p_four_period)
        else $error("four to one word period wrong");

    property p_seven_period; // Video takes every seven cycles
        @(posedge clk) disable iff (reset)
        word_take_q && mode_sel == OGS_SEL_SEVEN |=> !word_take_q [*6] ##1 word_take_q;
    endproperty
    a_seven_period: assert property (p_seven_period)
        else $error("video word period wrong");

    property p_eight_period; // One 8:1 gearbox takes every eight cycles
        @(posedge clk) disable iff (reset)
        word_take_q && ogs_decode(mode_sel) == OGS_EIGHT |=> !word_take_q [*7] ##1 word_take_q;
    endproperty
    a_eight_period: assert property (p_eight_period)
        else $error("eight to one word period wrong");

    // Spare select code behaves as one 8:1 gearbox
    c_spare: cover property (@(posedge clk) disable iff (reset)
        word_take_q && mode_sel != OGS_SEL_EIGHT && ogs_decode(mode_sel) == OGS_EIGHT
        ##8 word_take_q);

    c_seven: cover property (@(posedge clk) disable iff (reset)
        word_take_q && mode_sel == OGS_SEL_SEVEN ##7 word_take_q);
    c_eight: cover property (@(posedge clk) disable iff (reset)
        word_take_q && mode_sel == OGS_SEL_EIGHT ##8 word_take_q);
    c_four: cover property (@(posedge clk) disable iff (reset)
        load_q && four2_q ##1 serial_q == 2'h3);

endmodule : ogs_serializer

/* File: verif/ogs_core_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Core side model: offers one word in every take cycle
// ----------------------------------------------------------------
module ogs_core_model
    import ogs_pkg::*;
#(
    parameter logic [31:0] SEED = 32'h00000001 // Xorshift start value
)(
    input wire logic clk,
    input wire logic word_take_q,
    input wire logic [1:0] mode_req,
    input wire logic rand_mode,
    output logic [OGS_WORD_W-1:0] par_data,
    output logic [1:0] mode_sel,
    output logic sent
);
    logic [31:0] rnd_q; // Xorshift state

    // One xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    initial begin
        rnd_q = SEED;
        par_data = 8'h00;
        mode_sel = 2'h1;
        sent = 1'b0;
    end

    // Word valid only in take cycles, noise in all others
    always @(posedge clk) begin
        #1;
        rnd_q = xs(rnd_q);
        sent = word_take_q;
        if (word_take_q === 1'b1) begin
            // Full random word, so unused bits must be dropped
            par_data = rnd_q[7:0];
            // Fixed or random mode code, spare code included
            mode_sel = rand_mode ? rnd_q[9:8] : mode_req;
        end else begin
            // Changing junk that the design must ignore
            par_data = ~par_data ^ rnd_q[15:8];
            mode_sel = ~mode_sel;
        end
    end
endmodule : ogs_core_model

/* File: verif/test_output_gearbox_serializer.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bench: random words in every mode, checked bit by bit
// ----------------------------------------------------------------
module test_output_gearbox_serializer;
    import ogs_pkg::*;
    typedef struct {int due; logic [1:0] v;} ogs_exp_t; // Expected lanes in one cycle
    logic clk = 1'b0; // Fast clock
    logic reset = 1'b1; // Synchronous reset
    logic [1:0] mode_req = 2'h1; // Mode asked of the model
    logic rand_mode = 1'b0; // Model picks random modes
    logic [OGS_WORD_W-1:0] par_data; // Word from model
    logic [1:0] mode_sel; // Mode from model
    logic sent; // Model offered a word this cycle
    logic word_take_q; // Slow clock enable
    logic [OGS_LANES-1:0] serial_q; // Serial lanes
    int cyc = 0; // Cycle count
    int num_errors = 0;
    int n_tests = 0;
    int last_t; // Last take cycle
    int last_n; // Cycles to next take
    logic rst_d = 1'b1; // Reset of previous cycle
    ogs_exp_t exp_q[$]; // Notes of expected lanes
    ogs_exp_t e_n; // Note being built
    ogs_exp_t e_c; // Note being compared

    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    ogs_serializer dut (
        .clk(clk),
        .reset(reset),
        .mode_sel(mode_sel),
        .par_data(par_data),
        .word_take_q(word_take_q),
        .serial_q(serial_q)
    );

    ogs_core_model #(.SEED(32'he8ba6122)) core (
        .clk(clk),
        .word_take_q(word_take_q),
        .mode_req(mode_req),
        .rand_mode(rand_mode),
        .par_data(par_data),
        .mode_sel(mode_sel),
        .sent(sent)
    );

    // Word period of a mode code
    function automatic int n_of(input logic [1:0] s);
        case (s)
            OGS_SEL_SEVEN: return 7;
            OGS_SEL_FOUR: return 4;
            default: return 8;
        endcase
    endfunction : n_of

    // Mismatch report
    task automatic fail_chk(input string m);
        $display("[ERR] %0t %s", $time, m);
        num_errors++;
    endtask : fail_chk

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // -----------------------------------------------------------
    // Noter: take spacing and expected bits of each word
    // -----------------------------------------------------------
    always @(posedge clk) begin
        #2;
        if (reset) begin
            // Restart from a word boundary after release
            exp_q.delete();
            last_t = cyc + 1;
            last_n = 7;
        end else begin
            n_tests++;
            if (word_take_q !== (cyc == last_t + last_n)) fail_chk("take spacing");
            if (sent) begin
                last_t = cyc;
                last_n = n_of(mode_sel);
                // LSB first, three stages ahead of the lane
                for (int i = 0; i < last_n; i++) begin
                    e_n.due = cyc + 3 + i;
                    e_n.v[0] = par_data[i];
                    e_n.v[1] = (mode_sel == OGS_SEL_FOUR) ? par_data[(i + 4) % 8] : 1'b0;
                    exp_q.push_back(e_n);
                end
            end
        end
    end

    // -----------------------------------------------------------
    // Watcher: lanes against the oldest due note, else zero
    // -----------------------------------------------------------
    always @(posedge clk) begin
        #3;
        if (!(reset && !rst_d)) begin
            e_c.v = 2'h0;
            if (exp_q.size() > 0 && exp_q[0].due == cyc) begin
                e_c = exp_q.pop_front();
            end
            n_tests++;
            if (serial_q !== e_c.v) fail_chk("serial lanes");
        end
        rst_d = reset;
    end

    // -----------------------------------------------------------
    // Main sequence: mode codes 0 to 2, reset mid-word, random modes
    // -----------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        // Mode codes 0 to 2 in turn, switching mid-stream; code 3 is replaced at once by OGS_SEL_FOUR
        for (int m = 0; m < 4; m++) begin
            repeat (60) @(posedge clk);
            #1;
            mode_req = m[1:0];
        end
        mode_req = OGS_SEL_FOUR;
        repeat (43) @(posedge clk);
        #1;
        // Reset in the middle of a word
        reset = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        rand_mode = 1'b1;
        repeat (400) @(posedge clk);
        tally_and_finish();
    end
endmodule : test_output_gearbox_serializer
